// ### core/swd_top.sv
/*
 * Output control of a power-supply supervisor: watchdog timer, reset and
 * fault outputs, manual reset routing, margin hold, EEPROM write busy time,
 * with an AXI4-Lite register slave.
 * Assumes aresetn low while the internal supply is below the lockout level.
 */
// How it works
// - the watchdog output goes low when no kick edge arrives within the selected period.
// - initial and normal periods are set apart, each from 6.25 ms to 102.4 s.
// - all three outputs are active low and each drives either open drain or weak pull-up.
// - reset and fault outputs follow their conditions only once supply passes lockout.
// - control bits route the manual reset to the reset output, the fault output or both.
// - an EEPROM byte write stays busy for 11 ms and EEDATA writes meanwhile get SLVERR.
// - the very first configuration write takes one extra write cycle.
// - serial data, clock and address inputs ignore pulses shorter than 50 ns.
// - a low margin input freezes all three outputs in their present states.
// - margin hold wins over manual reset when both are asserted.
`timescale 1ns/10ps
`default_nettype none
module swd_top
#(
	parameter int unsigned WD_BASE     = swd_pkg::WD_BASE_CYC,
	parameter int unsigned EE_CYC      = swd_pkg::EE_WRITE_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output var  logic        s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output var  logic        s_axil_wready,
	output var  logic [1:0]  s_axil_bresp,
	output var  logic        s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [3:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output var  logic        s_axil_arready,
	output var  logic [31:0] s_axil_rdata,
	output var  logic [1:0]  s_axil_rresp,
	output var  logic        s_axil_rvalid,
	input  wire logic        s_axil_rready,
	input  wire logic        watchdog_kick_in,
	input  wire logic        manual_reset_in_n,
	input  wire logic        margin_in_n,
	input  wire logic        supply_fault_cond,
	input  wire logic        reset_cond,
	input  wire logic        serial_clock_in,
	input  wire logic        serial_data_in,
	input  wire logic        bus_address_select,
	output var  logic        serial_clock_clean,
	output var  logic        serial_data_clean,
	output var  logic        bus_address_clean,
	output var  logic        watchdog_timeout_out_n,
	output var  logic        watchdog_timeout_oe,
	output var  logic        supply_fault_out_n,
	output var  logic        supply_fault_oe,
	output var  logic        reset_out_n,
	output var  logic        reset_out_oe
);
	import swd_pkg::*;

	localparam int unsigned WDW = 36;
	localparam int unsigned EEW = 24;

	logic [11:0]     ctrl;
	logic [7:0]      eedata;
	logic            kick_q;
	logic            normal_phase;
	logic [WDW-1:0]  wd_cnt;
	logic            wdo_n;
	logic            rst_n;
	logic            flt_n;
	logic            first_done;
	logic            init_done;
	swd_ee_e         ee_state;
	logic [EEW-1:0]  ee_cnt;
	logic            aw_held;
	logic            w_held;
	logic [3:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;

	logic [2:0] raw_in;
	logic [2:0] clean_in;
	assign raw_in = {bus_address_select, serial_data_in, serial_clock_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			swd_filter #(.LEN(SPIKE_CYC)) u_filt (
				.aclk    (aclk),
				.aresetn (aresetn),
				.raw     (raw_in[gi]),
				.init    (!init_done),
				.clean   (clean_in[gi])
			);
		end
	endgenerate

	wire [2:0]     sel_code  = normal_phase ? ctrl[CTL_NORM_LSB +: 3] : ctrl[CTL_INIT_LSB +: 3];
	wire [WDW-1:0] period    = WDW'(WD_BASE) << (WD_STEP_SHIFT * sel_code);
	wire           kick_edge = watchdog_kick_in ^ kick_q;
	wire           expire    = (wd_cnt >= period - 1'b1);

	wire margin_hold = !margin_in_n;
	wire mr_active   = !manual_reset_in_n;
	wire next_rst_n  = !(reset_cond || (mr_active && ctrl[CTL_MR_RST]));
	wire next_flt_n  = !(supply_fault_cond || ctrl[CTL_FAULT_SW] ||
	                     (mr_active && ctrl[CTL_MR_FLT]));

	// bus decode
	wire wr_go   = aw_held && w_held && !s_axil_bvalid;
	wire wr_ctrl = wr_go && aw_addr == OFF_CTRL;
	wire wr_ee   = wr_go && aw_addr == OFF_EEDATA && ee_state == SWD_EE_IDLE;
	wire wr_ok   = aw_addr == OFF_CTRL || aw_addr == OFF_EEDATA;
	wire rd_go   = s_axil_arvalid && s_axil_arready;
	wire [31:0] status = {27'h0, first_done, ee_state != SWD_EE_IDLE, flt_n, rst_n, wdo_n};
	wire [31:0] rd_mux = (s_axil_araddr == OFF_CTRL)   ? {20'h0, ctrl}   :
	                     (s_axil_araddr == OFF_STATUS) ? status          :
	                     (s_axil_araddr == OFF_EEDATA) ? {24'h0, eedata} : 32'h0;
	wire rd_ok   = s_axil_araddr == OFF_CTRL || s_axil_araddr == OFF_STATUS ||
	               s_axil_araddr == OFF_EEDATA;
	wire ee_end  = ee_cnt == EEW'(EE_CYC - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kick_q       <= 1'b0;
			wd_cnt       <= '0;
			normal_phase <= 1'b0;
			init_done    <= 1'b0;
		end else begin
			kick_q    <= watchdog_kick_in;
			init_done <= 1'b1;
			if (!init_done || kick_edge) begin
				wd_cnt <= '0;
				if (init_done)
					normal_phase <= 1'b1;
			end else if (!expire) begin
				wd_cnt <= wd_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdo_n <= 1'b1;
			rst_n <= 1'b0;
			flt_n <= 1'b0;
		end else if (!margin_hold) begin
			wdo_n <= !(init_done && expire && !kick_edge);
			rst_n <= next_rst_n;
			flt_n <= next_flt_n;
		end
	end

	// active low, open drain or pull-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_timeout_out_n <= 1'b1;
			watchdog_timeout_oe    <= 1'b0;
			reset_out_n            <= 1'b0;
			reset_out_oe           <= 1'b1;
			supply_fault_out_n     <= 1'b0;
			supply_fault_oe        <= 1'b1;
			serial_clock_clean     <= 1'b0;
			serial_data_clean      <= 1'b0;
			bus_address_clean      <= 1'b0;
		end else begin
			watchdog_timeout_out_n <= wdo_n;
			watchdog_timeout_oe    <= !wdo_n || !ctrl[CTL_OD_WDO];
			reset_out_n            <= rst_n;
			reset_out_oe           <= !rst_n || !ctrl[CTL_OD_RST];
			supply_fault_out_n     <= flt_n;
			supply_fault_oe        <= !flt_n || !ctrl[CTL_OD_FLT];
			serial_clock_clean     <= clean_in[0];
			serial_data_clean      <= clean_in[1];
			bus_address_clean      <= clean_in[2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ee_state   <= SWD_EE_IDLE;
			ee_cnt     <= '0;
			first_done <= 1'b0;
		end else begin
			case (ee_state)
				SWD_EE_IDLE: begin
					ee_cnt <= '0;
					if (wr_ee)
						ee_state <= SWD_EE_WRITE;
				end
				SWD_EE_WRITE: begin
					ee_cnt <= ee_end ? '0 : ee_cnt + 1'b1;
					if (ee_end) begin
						ee_state   <= first_done ? SWD_EE_IDLE : SWD_EE_EXTRA;
						first_done <= 1'b1;
					end
				end
				SWD_EE_EXTRA: begin
					ee_cnt <= ee_end ? '0 : ee_cnt + 1'b1;
					if (ee_end)
						ee_state <= SWD_EE_IDLE;
				end
				default: ee_state <= SWD_EE_IDLE;
			endcase
		end
	end

	// AXI4-Lite write path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held        <= 1'b0;
			w_held         <= 1'b0;
			aw_addr        <= '0;
			w_data         <= '0;
			w_strb         <= '0;
			s_axil_awready <= 1'b0;
			s_axil_wready  <= 1'b0;
			s_axil_bvalid  <= 1'b0;
			s_axil_bresp   <= RESP_OKAY;
			ctrl           <= CTL_RESET;
			eedata         <= '0;
		end else begin
			s_axil_awready <= !aw_held && !s_axil_awready && s_axil_awvalid;
			s_axil_wready  <= !w_held && !s_axil_wready && s_axil_wvalid;
			if (s_axil_awvalid && s_axil_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axil_awaddr;
			end
			if (s_axil_wvalid && s_axil_wready) begin
				w_held <= 1'b1;
				w_data <= s_axil_wdata;
				w_strb <= s_axil_wstrb;
			end
			if (wr_go) begin
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= (wr_ok && (aw_addr != OFF_EEDATA || wr_ee)) ?
				                 RESP_OKAY : RESP_SLVERR;
			end else if (s_axil_bready) begin
				s_axil_bvalid <= 1'b0;
			end
			if (wr_ctrl && w_strb[0])
				ctrl[7:0] <= w_data[7:0];
			if (wr_ctrl && w_strb[1])
				ctrl[11:8] <= w_data[11:8];
			if (wr_ee && w_strb[0])
				eedata <= w_data[7:0];
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid  <= 1'b0;
			s_axil_rdata   <= '0;
			s_axil_rresp   <= RESP_OKAY;
		end else begin
			s_axil_arready <= !s_axil_arready && !s_axil_rvalid && s_axil_arvalid;
			if (rd_go) begin
				s_axil_rvalid <= 1'b1;
				s_axil_rdata  <= rd_mux;
				s_axil_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axil_rready) begin
				s_axil_rvalid <= 1'b0;
			end
		end
	end
endmodule : swd_top
`default_nettype wire

// ### core/swd_pkg.sv
/*
 * Constants for the supervisor output block: watchdog periods, filter
 * and busy times, register map of the AXI4-Lite slave.
 * Assumes a 100 MHz aclk.
 */
package swd_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned CLK_NS           = 10;
	// watchdog periods in microseconds per 3-bit code
	localparam int unsigned WD_BASE_US       = 6250;
	localparam int unsigned WD_MAX_US        = 102400000;
	localparam int unsigned WD_BASE_CYC      = WD_BASE_US * CLK_MHZ;
	// each code step multiplies the period by four
	localparam int unsigned WD_STEP_SHIFT    = 2;
	localparam int unsigned SPIKE_NS         = 50;
	localparam int unsigned SPIKE_CYC        = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned EE_WRITE_MS      = 11;
	localparam int unsigned EE_WRITE_CYC     = EE_WRITE_MS * 1000 * CLK_MHZ;
	localparam int unsigned EE_EXTRA_CYCLES  = 1;
	localparam int unsigned LOCKOUT_MV       = 2500;

	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_EEDATA = 4'h8;

	// ctrl fields
	localparam int unsigned CTL_INIT_LSB  = 0;
	localparam int unsigned CTL_NORM_LSB  = 3;
	localparam int unsigned CTL_MR_RST    = 6;
	localparam int unsigned CTL_MR_FLT    = 7;
	localparam int unsigned CTL_OD_RST    = 8;
	localparam int unsigned CTL_OD_FLT    = 9;
	localparam int unsigned CTL_OD_WDO    = 10;
	localparam int unsigned CTL_FAULT_SW  = 11;
	localparam logic [11:0] CTL_RESET     = 12'h0c0;

	// status fields
	localparam int unsigned ST_WDO     = 0;
	localparam int unsigned ST_RST     = 1;
	localparam int unsigned ST_FLT     = 2;
	localparam int unsigned ST_BUSY    = 3;
	localparam int unsigned ST_FIRST   = 4;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		SWD_EE_IDLE  = 2'b00,
		SWD_EE_WRITE = 2'b01,
		SWD_EE_EXTRA = 2'b10
	} swd_ee_e;
endpackage : swd_pkg

// ### core/swd_filter.sv
/*
 * Spike filter: a level is accepted only after it has stood for LEN
 * consecutive cycles, or at once while init is high. Input is synchronous to aclk.
 */
`timescale 1ns/10ps
`default_nettype none
module swd_filter #(
	parameter int unsigned LEN = 5
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw,
	input  wire logic init,
	output var  logic clean
);
	logic [$clog2(LEN+1)-1:0] run;
	wire                      same  = (raw == clean);
	wire                      done  = (run == ($clog2(LEN+1))'(LEN - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clean <= 1'b0;
			run   <= '0;
		end else if (init) begin
			clean <= raw;
			run   <= '0;
		end else if (same) begin
			run <= '0;
		end else if (done) begin
			clean <= raw;
			run   <= '0;
		end else begin
			run <= run + 1'b1;
		end
	end
endmodule : swd_filter
`default_nettype wire

// ### sim/swd_top_props.sv
/* checker on swd_top ports: watchdog, output levels, margin hold, filters.
   assumes the design pins as inputs; attached by bind. */
`timescale 1ns/10ps
`default_nettype none
module swd_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic watchdog_kick_in,
	input wire logic manual_reset_in_n,
	input wire logic margin_in_n,
	input wire logic supply_fault_cond,
	input wire logic reset_cond,
	input wire logic serial_data_in,
	input wire logic bus_address_select,
	input wire logic serial_data_clean,
	input wire logic bus_address_clean,
	input wire logic watchdog_timeout_out_n,
	input wire logic watchdog_timeout_oe,
	input wire logic supply_fault_out_n,
	input wire logic supply_fault_oe,
	input wire logic reset_out_n,
	input wire logic reset_out_oe
);
	logic [1:0] up;
	// outputs are live from the third edge after release
	always_ff @(posedge aclk) begin
		if (!aresetn)
			up <= 2'd0;
		else if (up != 2'd3)
			up <= up + 2'd1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_WDO_KICK: assert property (
		($changed(watchdog_kick_in) && margin_in_n && $past(margin_in_n)) ##1 margin_in_n
		##1 margin_in_n |-> watchdog_timeout_out_n) else $error("watchdog low after kick");
	AST_WDO_FALL: assert property (
		$fell(watchdog_timeout_out_n) |-> $past(watchdog_kick_in, 1) == $past(watchdog_kick_in, 2)
		&& $past(watchdog_kick_in, 2) == $past(watchdog_kick_in, 3)) else $error("early timeout");
	AST_FREEZE: assert property (
		(!margin_in_n && up == 2'd3) [*4] |-> $stable(reset_out_n) && $stable(supply_fault_out_n)
		&& $stable(watchdog_timeout_out_n)) else $error("output moved under margin hold");
	AST_DRIVE_LOW: assert property (
		(reset_out_n || reset_out_oe) && (supply_fault_out_n || supply_fault_oe)
		&& (watchdog_timeout_out_n || watchdog_timeout_oe)) else $error("low output undriven");
	AST_RST_SET: assert property (
		(reset_cond && margin_in_n && up == 2'd3) [*4] |-> !reset_out_n)
		else $error("reset output not asserted");
	AST_RST_CLEAR: assert property (
		(!reset_cond && manual_reset_in_n && margin_in_n && up == 2'd3) [*4] |-> reset_out_n)
		else $error("reset output stuck low");
	AST_FLT_SET: assert property (
		(supply_fault_cond && margin_in_n && up == 2'd3) [*4] |-> !supply_fault_out_n)
		else $error("fault output not asserted");
	AST_FILT_DATA: assert property (
		$changed(serial_data_clean) |-> $past(serial_data_in, 2) == serial_data_clean
		&& $past(serial_data_in, 4) == serial_data_clean && $past(serial_data_in, 6) == serial_data_clean)
		else $error("data filter passed a spike");
	AST_FILT_ADDR: assert property (
		$changed(bus_address_clean) |-> $past(bus_address_select, 2) == bus_address_clean
		&& $past(bus_address_select, 6) == bus_address_clean) else $error("address filter spike");
	cover property (!watchdog_timeout_out_n);
	cover property (!margin_in_n && !manual_reset_in_n);
	cover property ($rose(serial_data_clean));
endmodule : swd_top_props
bind swd_top swd_top_props u_swd_top_props (.aclk, .aresetn, .watchdog_kick_in,
	.manual_reset_in_n, .margin_in_n, .supply_fault_cond, .reset_cond, .serial_data_in,
	.bus_address_select, .serial_data_clean, .bus_address_clean, .watchdog_timeout_out_n,
	.watchdog_timeout_oe, .supply_fault_out_n, .supply_fault_oe, .reset_out_n, .reset_out_oe);
`default_nettype wire

// ### sim/swd_host_model.sv
/* host processor stand-in: toggles the kick input every gap+1 cycles.
   assumes it stops kicking while held in reset by the supervisor. */
`timescale 1ns/10ps
`default_nettype none
module swd_host_model (
	input  wire logic       aclk,
	input  wire logic       run,
	input  wire logic [7:0] gap,
	input  wire logic       reset_out_n,
	output var  logic       kick
);
	logic [7:0] cnt = 8'h00;
	initial kick = 1'b0;
	always @(posedge aclk) begin
		if (!run || !reset_out_n)
			cnt <= 8'h00;
		else if (cnt >= gap) begin
			cnt <= 8'h00;
			kick <= ~kick;
		end else
			cnt <= cnt + 8'h01;
	end
endmodule : swd_host_model
`default_nettype wire

// ### sim/tb_swd_top.sv
/* bench for swd_top: register bus, watchdog, outputs, filters, write busy.
   assumes small period parameters and the host model on the kick input. */
`timescale 1ns/10ps
`default_nettype none
module tb_swd_top;
	import swd_pkg::*;
	logic aclk = 0, aresetn = 0, s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
	logic s_axil_arvalid = 0, s_axil_rready = 0, s_axil_awready, s_axil_wready, s_axil_bvalid;
	logic [3:0] s_axil_awaddr = 0, s_axil_wstrb = 4'hf, s_axil_araddr = 0;
	logic [31:0] s_axil_wdata = 0, s_axil_rdata;
	logic [1:0] s_axil_bresp, s_axil_rresp;
	logic s_axil_arready, s_axil_rvalid, watchdog_kick_in, manual_reset_in_n = 1, margin_in_n = 1;
	logic supply_fault_cond = 0, reset_cond = 0, run = 1, serial_clock_clean, serial_data_clean;
	logic bus_address_clean, watchdog_timeout_out_n, watchdog_timeout_oe, supply_fault_out_n;
	logic supply_fault_oe, reset_out_n, reset_out_oe;
	logic [2:0] sr = 0;
	logic [7:0] gap = 1;
	logic [33:0] bq[$], rq[$];
	int n_mismatch = 0, tests_run = 0, seed = 43637;
	wire logic [5:0] pins = {watchdog_timeout_oe, supply_fault_oe, reset_out_oe,
		watchdog_timeout_out_n, supply_fault_out_n, reset_out_n};
	swd_top #(.WD_BASE(4), .EE_CYC(8)) u_swd_top (.aclk, .aresetn, .s_axil_awaddr,
		.s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
		.s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
		.s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
		.s_axil_rready, .watchdog_kick_in, .manual_reset_in_n, .margin_in_n, .supply_fault_cond,
		.reset_cond, .serial_clock_in(sr[0]), .serial_data_in(sr[1]), .bus_address_select(sr[2]),
		.serial_clock_clean, .serial_data_clean, .bus_address_clean, .watchdog_timeout_out_n,
		.watchdog_timeout_oe, .supply_fault_out_n, .supply_fault_oe, .reset_out_n, .reset_out_oe);
	swd_host_model u_swd_host_model (.aclk, .run, .gap, .reset_out_n, .kick(watchdog_kick_in));
	initial forever #5 aclk = ~aclk;
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chkp(input logic [5:0] m, input logic [5:0] e);
		chk(34'(pins & m), 34'(e));
	endtask : chkp
	task automatic conclude;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic tmo(input int n);
		if (n >= 40) begin
			n_mismatch++;
			conclude();
		end
	endtask : tmo
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		bq.push_back({e, 32'h0});
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1;
		s_axil_wvalid <= 1;
		s_axil_bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axil_awready) s_axil_awvalid <= 0;
			if (s_axil_wready) s_axil_wvalid <= 0;
		end while (!s_axil_bvalid && n < 40);
		s_axil_bready <= 0;
		tmo(n);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		rq.push_back(e);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1;
		s_axil_rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axil_arready) s_axil_arvalid <= 0;
		end while (!s_axil_rvalid && n < 40);
		s_axil_rready <= 0;
		tmo(n);
	endtask : rd
	always @(posedge aclk) begin
		if (s_axil_bvalid && s_axil_bready) chk({s_axil_bresp, 32'h0}, bq.pop_front());
		if (s_axil_rvalid && s_axil_rready) chk({s_axil_rresp, s_axil_rdata}, rq.pop_front());
	end
	initial begin
		int p;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rd(OFF_CTRL, {RESP_OKAY, 20'h0, CTL_RESET});
		rd(OFF_STATUS, {RESP_OKAY, 32'h7});
		rd(4'hc, {RESP_SLVERR, 32'h0});
		wr(OFF_STATUS, 32'h0, RESP_SLVERR);
		wr(OFF_EEDATA, 32'h5a, RESP_OKAY);
		repeat (6) @(posedge aclk);
		wr(OFF_EEDATA, 32'h5a, RESP_SLVERR);
		repeat (8) @(posedge aclk);
		rd(OFF_STATUS, {RESP_OKAY, 32'h17});
		rd(OFF_EEDATA, {RESP_OKAY, 32'h5a});
		wr(OFF_EEDATA, 32'ha5, RESP_OKAY);
		wr(OFF_EEDATA, 32'ha5, RESP_SLVERR);
		repeat (10) @(posedge aclk);
		wr(OFF_EEDATA, 32'h3c, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			{reset_cond, supply_fault_cond} <= 2'($random(seed));
			repeat (6) @(posedge aclk);
			chkp(6'h03, {4'h0, ~supply_fault_cond, ~reset_cond});
		end
		{reset_cond, supply_fault_cond} <= 2'b00;
		for (int k = 4; k < 9; k += 4) begin
			sr <= 3'h7;
			repeat (k) @(posedge aclk);
			sr <= 3'h0;
			repeat (2) @(posedge aclk);
			chk(34'({bus_address_clean, serial_data_clean, serial_clock_clean}), 34'(k > 4 ? 7 : 0));
			repeat (8) @(posedge aclk);
		end
		for (int c = 1; c < 3; c++) begin
			p = 4 << (2 * c);
			wr(OFF_CTRL, 32'h0c0 | 32'(c << 3), RESP_OKAY);
			gap <= 8'(p / 2 - 1);
			repeat (p) @(posedge aclk);
			run <= 0;
			repeat (p / 2 - 2) @(posedge aclk);
			chkp(6'h04, 6'h04);
			repeat (p / 2 + 7) @(posedge aclk);
			chkp(6'h04, 6'h00);
			margin_in_n <= 0;
			manual_reset_in_n <= 0;
			run <= 1;
			repeat (p) @(posedge aclk);
			chkp(6'h07, 6'h03);
			margin_in_n <= 1;
			manual_reset_in_n <= 1;
			repeat (6) @(posedge aclk);
			chkp(6'h07, 6'h07);
		end
		gap <= 1;
		for (int k = 0; k < 8; k++) begin
			wr(OFF_CTRL, 32'(((k & 3) << 6) | (k << 8)), RESP_OKAY);
			manual_reset_in_n <= 0;
			repeat (6) @(posedge aclk);
			chkp(6'h03, {4'h0, ~k[1], ~k[0]});
			manual_reset_in_n <= 1;
			repeat (10) @(posedge aclk);
			chkp(6'h3f, {~3'(k), 3'h7});
		end
		// software fault force, then read back control and status
		wr(OFF_CTRL, 32'h800, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chkp(6'h02, 6'h00);
		rd(OFF_CTRL, {RESP_OKAY, 32'h800});
		rd(OFF_STATUS, {RESP_OKAY, 32'h13});
		// mid-run reset: initial period code 1 must govern before any kick
		run <= 0;
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		wr(OFF_CTRL, 32'h0c1, RESP_OKAY);
		repeat (8) @(posedge aclk);
		chkp(6'h04, 6'h04);
		repeat (8) @(posedge aclk);
		chkp(6'h04, 6'h00);
		conclude();
	end
endmodule : tb_swd_top
`default_nettype wire
